// ===== rtl/flrpc_pkg.sv
// Package of timing constants and enumerations for the fan lock and restart control
package flrpc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned TON_MS = 500;
    localparam int unsigned TOFF_MS = 5000;
    localparam int unsigned PWM_LOW_MS = 70;
    localparam int unsigned PWM_MIN_HZ = 15;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    localparam int unsigned TON_TICKS = TON_MS;
    localparam int unsigned TOFF_TICKS = TOFF_MS;
    localparam int unsigned PWM_LOW_TICKS = PWM_LOW_MS;
    localparam int unsigned PWM_SLOW_TICKS = 1000 / PWM_MIN_HZ;
    localparam int unsigned SOFT_START_TICKS = 100;
    localparam int unsigned SOFT_HALF_CYC = 500;

    // ****************************************************************
    // States
    // ****************************************************************
    typedef enum logic [1:0] {
        FLRPC_RUN = 2'b00,
        FLRPC_LOCK_ON = 2'b01,
        FLRPC_LOCK_OFF = 2'b10,
        FLRPC_SOFT = 2'b11
    } flrpc_state_t;

endpackage

// ===== rtl/flrpc_tick_div.sv
// Divider that turns the system clock into a one-cycle millisecond tick enable
`timescale 1ns/1ps
`default_nettype none
module flrpc_tick_div #(
    parameter int unsigned DIV = flrpc_pkg::TICK_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } flrpc_div_t;

    flrpc_div_t r;
    flrpc_div_t next_r;

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.cnt == 16'(DIV - 1)) begin
            next_r.cnt = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule
`default_nettype wire

// ===== rtl/flrpc_ctrl.sv
// Lock detection, auto restart, soft start and PWM gating for a single-phase fan pre-driver
`timescale 1ns/1ps
`default_nettype none
module flrpc_ctrl #(
    parameter int unsigned TON_TICKS = flrpc_pkg::TON_TICKS,
    parameter int unsigned TOFF_TICKS = flrpc_pkg::TOFF_TICKS,
    parameter int unsigned TICK_CYC = flrpc_pkg::TICK_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hall_pos_gt,
    input wire logic pwm_in,
    input wire logic pwm_open,
    input wire logic min_speed_set_input,
    output logic drive_out_a,
    output logic drive_out_b,
    output logic speed_pulse_out_o,
    output logic speed_pulse_out_oe_n,
    output logic lock_prot_off
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        flrpc_pkg::flrpc_state_t st;
        logic [12:0] tcnt;
        logic [6:0] lowcnt;
        logic [6:0] percnt;
        logic pwm_slow;
        logic prot_off;
        logic hall_q;
        logic pwm_q;
        logic [9:0] chop;
        logic chop_ph;
        logic out_a;
        logic out_b;
        logic fg_oe_n;
    } flrpc_ctrl_t;

    flrpc_ctrl_t r;
    flrpc_ctrl_t next_r;
    logic tick;
    logic pwm_eff;
    logic hall_edge;
    logic prot_en;

    flrpc_tick_div #(.DIV(TICK_CYC)) u_div (
        .mclk(mclk),
        .rstn(rstn),
        .tick(tick)
    );

    // Floating PWM reads as high
    assign pwm_eff = pwm_in | pwm_open;
    assign hall_edge = hall_pos_gt ^ r.hall_q;
    assign prot_en = !r.prot_off && !r.pwm_slow;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic run_a;
        logic run_b;
        run_a = 1'b0;
        run_b = 1'b0;
        next_r = r;
        next_r.hall_q = hall_pos_gt;
        next_r.pwm_q = pwm_eff;
        // PWM low time and period measurement in ms ticks
        if (pwm_eff) begin
            next_r.lowcnt = 7'h00;
            next_r.prot_off = 1'b0;
        end else if (tick && r.lowcnt != 7'h7F) begin
            next_r.lowcnt = r.lowcnt + 7'h01;
        end
        if (min_speed_set_input && r.lowcnt > 7'(flrpc_pkg::PWM_LOW_TICKS)) begin
            next_r.prot_off = 1'b1;
        end
        if (pwm_eff && !r.pwm_q) begin
            next_r.pwm_slow = (r.percnt > 7'(flrpc_pkg::PWM_SLOW_TICKS));
            next_r.percnt = 7'h00;
        end else if (tick && r.percnt != 7'h7F) begin
            next_r.percnt = r.percnt + 7'h01;
            if (r.percnt >= 7'(flrpc_pkg::PWM_SLOW_TICKS) && !pwm_eff) begin
                next_r.pwm_slow = 1'b1;
            end
        end
        // 50 percent chopper
        if (r.chop == 10'(flrpc_pkg::SOFT_HALF_CYC - 1)) begin
            next_r.chop = 10'h000;
            next_r.chop_ph = !r.chop_ph;
        end else begin
            next_r.chop = r.chop + 10'h001;
        end
        if (tick) begin
            next_r.tcnt = r.tcnt + 13'h0001;
        end
        unique case (r.st)
            flrpc_pkg::FLRPC_RUN: begin
                if (hall_edge || !prot_en) begin
                    next_r.tcnt = 13'h0000;
                end else if (r.tcnt >= 13'(TON_TICKS)) begin
                    next_r.st = flrpc_pkg::FLRPC_LOCK_OFF;
                    next_r.tcnt = 13'h0000;
                end
            end
            flrpc_pkg::FLRPC_LOCK_ON: begin
                if (hall_edge || !prot_en) begin
                    next_r.st = flrpc_pkg::FLRPC_SOFT;
                    next_r.tcnt = 13'h0000;
                end else if (r.tcnt >= 13'(TON_TICKS)) begin
                    next_r.st = flrpc_pkg::FLRPC_LOCK_OFF;
                    next_r.tcnt = 13'h0000;
                end
            end
            flrpc_pkg::FLRPC_LOCK_OFF: begin
                if (r.tcnt >= 13'(TOFF_TICKS)) begin
                    next_r.st = flrpc_pkg::FLRPC_LOCK_ON;
                    next_r.tcnt = 13'h0000;
                end
            end
            flrpc_pkg::FLRPC_SOFT: begin
                if (r.tcnt >= 13'(flrpc_pkg::SOFT_START_TICKS)) begin
                    next_r.st = flrpc_pkg::FLRPC_RUN;
                    next_r.tcnt = 13'h0000;
                end
            end
        endcase
        // Output drive
        run_a = hall_pos_gt;
        run_b = !hall_pos_gt;
        unique case (next_r.st)
            flrpc_pkg::FLRPC_LOCK_OFF: begin
                next_r.out_a = 1'b0;
                next_r.out_b = 1'b0;
            end
            flrpc_pkg::FLRPC_SOFT: begin
                next_r.out_a = run_a && pwm_eff && next_r.chop_ph;
                next_r.out_b = run_b && next_r.chop_ph;
            end
            flrpc_pkg::FLRPC_RUN, flrpc_pkg::FLRPC_LOCK_ON: begin
                next_r.out_a = run_a && pwm_eff;
                next_r.out_b = run_b;
            end
        endcase
        next_r.fg_oe_n = !hall_pos_gt;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            r <= '0;
            r.st <= flrpc_pkg::FLRPC_LOCK_ON;
            r.pwm_q <= 1'b1;
            r.fg_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign drive_out_a = r.out_a;
    assign drive_out_b = r.out_b;
    assign speed_pulse_out_o = 1'b0;
    assign speed_pulse_out_oe_n = r.fg_oe_n;
    assign lock_prot_off = !prot_en;

    // ****************************************************************
    // Checks
    // ****************************************************************
    lock_off_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_LOCK_OFF) |-> (!drive_out_a && !drive_out_b))
        else $error("drives active during lock off");
    off_no_escape_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_LOCK_OFF && r.tcnt < 13'(TOFF_TICKS)) |=> (r.st != flrpc_pkg::FLRPC_SOFT))
        else $error("left lock off before interval ended");
    on_hall_resume_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_LOCK_ON && hall_edge) |=> (r.st == flrpc_pkg::FLRPC_SOFT))
        else $error("hall edge in drive on did not resume");
    pwm_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!pwm_in && !pwm_open) |=> !drive_out_a)
        else $error("high side on with pwm low");
    fg_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        hall_pos_gt |=> !speed_pulse_out_oe_n)
        else $error("speed pulse not pulled low");
    off_timeout_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_LOCK_OFF && r.tcnt >= 13'(TOFF_TICKS)) |=> (r.st == flrpc_pkg::FLRPC_LOCK_ON))
        else $error("drive off interval overrun");
    on_timeout_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_LOCK_ON && !hall_edge && prot_en && r.tcnt >= 13'(TON_TICKS))
        |=> (r.st == flrpc_pkg::FLRPC_LOCK_OFF))
        else $error("drive on interval overrun");
    prot_off_a: assert property (@(posedge mclk) disable iff (!rstn)
        (min_speed_set_input && !pwm_in && !pwm_open && r.lowcnt > 7'(flrpc_pkg::PWM_LOW_TICKS))
        |=> r.prot_off)
        else $error("protection not turned off after long pwm low");
    open_full_a: assert property (@(posedge mclk) disable iff (!rstn)
        (pwm_open && r.st == flrpc_pkg::FLRPC_RUN && next_r.st == flrpc_pkg::FLRPC_RUN && hall_pos_gt)
        |=> drive_out_a)
        else $error("open pwm did not give full drive");
    soft_chop_a: assert property (@(posedge mclk) disable iff (!rstn)
        (next_r.st == flrpc_pkg::FLRPC_SOFT && !next_r.chop_ph) |=> (!drive_out_a && !drive_out_b))
        else $error("drive active in soft start off phase");
    soft_end_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_SOFT && r.tcnt >= 13'(flrpc_pkg::SOFT_START_TICKS))
        |=> (r.st == flrpc_pkg::FLRPC_RUN))
        else $error("soft start did not end");
    slow_no_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_RUN && r.pwm_slow) |=> (r.st == flrpc_pkg::FLRPC_RUN))
        else $error("lock protection acted with slow pwm");
    fg_release_a: assert property (@(posedge mclk) disable iff (!rstn)
        !hall_pos_gt |=> speed_pulse_out_oe_n)
        else $error("speed pulse held low with hall low");
    run_restart_a: assert property (@(posedge mclk) disable iff (!rstn)
        (r.st == flrpc_pkg::FLRPC_RUN && hall_edge) |=> (r.tcnt == 13'h0000))
        else $error("hall edge did not restart lock timer");
endmodule
`default_nettype wire

// ===== dv/flrpc_partner.sv
// Hall comparator and PWM speed source model facing the fan control block
`timescale 1ns/1ps
`default_nettype none
module flrpc_partner (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic spin,
    input wire logic [15:0] pwm_hi,
    input wire logic [15:0] pwm_lo,
    input wire logic pwm_float,
    output logic hall_pos_gt,
    output logic pwm_in,
    output logic pwm_open
);
    logic [7:0] hcnt;
    logic [15:0] pcnt;
    assign pwm_open = pwm_float;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hcnt <= 8'h00;
            pcnt <= 16'h0000;
            hall_pos_gt <= 1'b0;
            pwm_in <= 1'b1;
        end else begin
            hcnt <= (hcnt == 8'h1D) ? 8'h00 : hcnt + 8'h01;
            pcnt <= pcnt + 16'h0001;
            if (spin && hcnt == 8'h1D) begin
                hall_pos_gt <= !hall_pos_gt;
            end
            // Open pin: level on the wire is meaningless, so it wanders
            if (pwm_float) begin
                pwm_in <= !pwm_in;
            end else if (pwm_in && pcnt >= pwm_hi && pwm_lo != 16'h0000) begin
                pwm_in <= 1'b0;
                pcnt <= 16'h0000;
            end else if (!pwm_in && pcnt >= pwm_lo && pwm_hi != 16'h0000) begin
                pwm_in <= 1'b1;
                pcnt <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking testbench for the fan lock and restart control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic spin = 1'b0;
    logic pwm_float = 1'b0;
    logic min_speed_set_input = 1'b0;
    logic [15:0] pwm_hi = 16'h0001;
    logic [15:0] pwm_lo = 16'h0000;
    logic hall_pos_gt, pwm_in, pwm_open, drive_out_a, drive_out_b, pulse_o, pulse_oe_n, lock_prot_off;
    int errors = 0;
    int num_checks = 0;
    always #12.5 mclk = ~mclk;
    flrpc_partner flrpc_partner_i (.mclk(mclk), .rstn(rstn), .spin(spin), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo),
        .pwm_float(pwm_float), .hall_pos_gt(hall_pos_gt), .pwm_in(pwm_in), .pwm_open(pwm_open));
    flrpc_ctrl #(.TON_TICKS(5), .TOFF_TICKS(20), .TICK_CYC(20)) flrpc_ctrl_i (.mclk(mclk), .rstn(rstn),
        .hall_pos_gt(hall_pos_gt), .pwm_in(pwm_in), .pwm_open(pwm_open), .min_speed_set_input(min_speed_set_input),
        .drive_out_a(drive_out_a), .drive_out_b(drive_out_b), .speed_pulse_out_o(pulse_o),
        .speed_pulse_out_oe_n(pulse_oe_n), .lock_prot_off(lock_prot_off));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic test_lock;
        cycles(130);
        @(posedge mclk) spin <= 1'b1;
        for (int i = 0; i < 330; i++) begin
            cycles(1);
            chk({drive_out_a, drive_out_b}, 16'h0000);
        end
        $display("test lock done");
    endtask
    task automatic test_soft;
        int n;
        int cnt;
        n = 0;
        cnt = 0;
        while (!(drive_out_a | drive_out_b) && n < 300) begin
            cycles(1);
            n++;
        end
        for (int i = 0; i < 2000; i++) begin
            cnt += int'(drive_out_a | drive_out_b);
            cycles(1);
        end
        chk(16'(cnt >= 800 && cnt <= 1200), 16'h0001);
        $display("test soft start done");
    endtask
    task automatic test_follow(input int n);
        logic ph;
        logic pp;
        cycles(1);
        for (int i = 0; i < n; i++) begin
            ph = hall_pos_gt;
            pp = pwm_in | pwm_open;
            cycles(1);
            chk({pulse_o, drive_out_a, drive_out_b, pulse_oe_n}, {1'b0, ph & pp, ~ph, ~ph});
        end
        $display("test follow done");
    endtask
    task automatic test_prot_off;
        @(posedge mclk);
        min_speed_set_input <= 1'b1;
        pwm_hi <= 16'h0000;
        pwm_lo <= 16'h0001;
        cycles(1500);
        chk(16'(lock_prot_off), 16'h0001);
        chk(16'(flrpc_ctrl_i.r.prot_off), 16'h0001);
        @(posedge mclk) spin <= 1'b0;
        cycles(300);
        chk({drive_out_a, drive_out_b}, {1'b0, ~hall_pos_gt});
        $display("test protection off done");
    endtask
    task automatic test_slow;
        logic seen;
        logic held;
        @(posedge mclk);
        min_speed_set_input <= 1'b0;
        spin <= 1'b1;
        pwm_hi <= 16'h00C8;
        pwm_lo <= 16'h0708;
        cycles(2000);
        held = 1'b1;
        for (int i = 0; i < 4000; i++) begin
            cycles(1);
            held = held & (lock_prot_off === 1'b1);
        end
        chk(16'(held), 16'h0001);
        @(posedge mclk);
        pwm_hi <= 16'h01F4;
        pwm_lo <= 16'h01F4;
        cycles(2000);
        seen = 1'b0;
        for (int i = 0; i < 2000; i++) begin
            cycles(1);
            seen = seen | (lock_prot_off !== 1'b0);
        end
        chk(16'(seen), 16'h0000);
        $display("test slow pwm done");
    endtask
    task automatic test_intervals;
        int n;
        int off_len;
        int on_len;
        n = 0;
        off_len = 0;
        on_len = 0;
        @(posedge mclk);
        pwm_hi <= 16'h0001;
        pwm_lo <= 16'h0000;
        cycles(600);
        @(posedge mclk) spin <= 1'b0;
        while ((drive_out_a | drive_out_b) && n < 300) begin
            cycles(1);
            n++;
        end
        while (!(drive_out_a | drive_out_b) && off_len < 1000) begin
            cycles(1);
            off_len++;
        end
        while ((drive_out_a | drive_out_b) && on_len < 1000) begin
            cycles(1);
            on_len++;
        end
        chk(16'(off_len >= 280 && off_len <= 520), 16'h0001);
        chk(16'(on_len >= 70 && on_len <= 130), 16'h0001);
        $display("test intervals done");
    endtask
    initial begin
        cycles(8);
        chk({drive_out_a, drive_out_b, pulse_oe_n}, 16'h0001);
        @(posedge mclk) rstn <= 1'b1;
        test_lock();
        test_soft();
        @(posedge mclk);
        pwm_hi <= 16'h0025;
        pwm_lo <= 16'h0017;
        test_follow(200);
        @(posedge mclk) pwm_float <= 1'b1;
        test_follow(200);
        @(posedge mclk) pwm_float <= 1'b0;
        test_prot_off();
        test_slow();
        test_intervals();
        complete_run();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
